// File: rsr_pkg.sv
`default_nettype none
package rsr_pkg;

	// ************************************************************
	// sequencer states, gray coded along the normal path
	// ************************************************************
	typedef enum logic [2:0] {
		RSR_ST_RESET = 3'h0,
		RSR_ST_WAIT  = 3'h1,
		RSR_ST_VLO   = 3'h3,
		RSR_ST_VHI   = 3'h2,
		RSR_ST_LOAD  = 3'h6,
		RSR_ST_RUN   = 3'h7,
		RSR_ST_STOP  = 3'h5,
		RSR_ST_SWAIT = 3'h4
	} rsr_state_t;

	// ************************************************************
	// stabilization wait, counted in main clock periods
	// ************************************************************
	localparam int          RSR_STAB_EXP    = 17;
	localparam int          RSR_STAB_PERIODS = 2 ** RSR_STAB_EXP;
	localparam int          RSR_CNT_W       = 18;

	// ************************************************************
	// reset vector and post-reset register values
	// ************************************************************
	localparam logic [15:0] RSR_VEC_ADDR_LO = 16'h0000;
	localparam logic [15:0] RSR_VEC_ADDR_HI = 16'h0001;
	localparam logic [7:0]  RSR_PSW_RST     = 8'h02;
	localparam logic [7:0]  RSR_PORT_RST    = 8'h00;
	localparam logic [7:0]  RSR_PMODE_RST   = 8'hff;
	localparam logic [7:0]  RSR_PULLUP_RST  = 8'h00;
	localparam logic [7:0]  RSR_PCC_RST     = 8'h04;
	localparam logic [7:0]  RSR_IMS_RST     = 8'hcf;
	localparam logic [7:0]  RSR_STABILIZATION_TIME_SELECT_RST    = 8'h04;
	localparam logic [7:0]  RSR_TIMER_RST   = 8'h00;

	// ************************************************************
	// register port map and fields
	// ************************************************************
	localparam logic [1:0]  RSR_REG_STATUS  = 2'h0;
	localparam logic [1:0]  RSR_REG_CAUSE   = 2'h1;
	localparam logic [1:0]  RSR_REG_CTRL    = 2'h2;
	localparam int          RSR_CAUSE_EXT   = 0;
	localparam int          RSR_CAUSE_WDT   = 1;
	localparam int          RSR_CAUSE_CLK   = 2;
	localparam int          RSR_CTRL_STOP   = 0;

	// ************************************************************
	// values handed to the core and peripherals at reset end
	// ************************************************************
	typedef struct packed {
		logic [7:0] program_status_word;
		logic [7:0] port_latch;
		logic [7:0] port_mode;
		logic [7:0] pull_up;
		logic [7:0] processor_clock_control;
		logic [7:0] memory_size_select;
		logic [7:0] stabilization_time_select;
		logic [7:0] timer_clr;
	} rsr_init_t;

	localparam rsr_init_t RSR_INIT_VALUES = '{
		program_status_word:        RSR_PSW_RST,
		port_latch: RSR_PORT_RST,
		port_mode:  RSR_PMODE_RST,
		pull_up:    RSR_PULLUP_RST,
		processor_clock_control:        RSR_PCC_RST,
		memory_size_select:        RSR_IMS_RST,
		stabilization_time_select:       RSR_STABILIZATION_TIME_SELECT_RST,
		timer_clr:  RSR_TIMER_RST
	};

	// ************************************************************
	// interrupt request that woke the device
	// ************************************************************
	typedef struct packed {
		logic req;
		logic mask;
		logic prio;
		logic enable;
		logic in_service;
	} rsr_irq_t;

endpackage
`default_nettype wire

// File: rsr_reset_and_stop_release.sv
// Summary of operation
// R1 - reset is raised by a low reset pin, a watchdog overrun or a main clock failure.
// R2 - every reset kind behaves alike and loads the program counter from bytes 0000H and 0001H.
// R3 - port pins are high impedance during reset and during the following stabilization wait.
// R4 - after the reset pin goes high execution starts only after 2^17 main clock periods.
// R5 - a watchdog reset releases itself and execution resumes after the same 2^17 period wait.
// R6 - during reset the main oscillator is stopped while the subsystem oscillator keeps running.
// R7 - a reset that ends STOP keeps the retained STOP state except that port pins float.
// R8 - a reset during STOP leaves STOP, waits out stabilization, then does normal reset work.
// R9 - an unmasked request ends STOP and is serviced per enable and in-service priority flags.
// R10 - a request whose mask flag is 1 leaves the device in STOP whatever the other flags.
// R11 - after reset the program counter holds the vector, stack pointer is undefined, PROGRAM_STATUS_WORD is 02H.
// R12 - during reset and the wait only the program counter is undefined, other state is kept.
// R13 - data memory is undefined after power-on but kept across a reset taken from standby.
// R14 - reset sets port latches and pull-ups 00H, directions FFH, clock 04H, size CFH, stabilization_time_select 04H.
// R15 - reset clears all timer, watchdog and clock output select registers to 00H; the code carries only timer_clr, set to 00H.
// R16 - an interrupt wake from STOP waits out stabilization, then services or resumes.
// R17 - the wait is a main clock counter that holds reset or the stall until terminal count.
//
// Strobed register access and the address map were decided locally.
`default_nettype none
module rsr_reset_and_stop_release #(
	parameter int STAB_CYCLES = rsr_pkg::RSR_STAB_PERIODS
) (
	input  wire logic              CORE_CLK,
	input  wire logic              RST_N,
	input  wire logic              RESET_PIN_N,
	input  wire logic              WDT_OVERRUN,
	input  wire logic              MAIN_CLK_FAIL,
	input  wire rsr_pkg::rsr_irq_t IRQ,
	input  wire logic [7:0]        VEC_DATA,
	input  wire logic [1:0]        REG_ADDR,
	input  wire logic [7:0]        REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic [7:0]             REG_RDATA,
	output logic                   CORE_RESET,
	output logic                   CPU_STALL,
	output logic                   PORT_HIZ,
	output logic                   MAIN_OSC_EN,
	output logic                   SUB_OSC_EN,
	output logic                   VEC_RD,
	output logic [15:0]            VEC_ADDR,
	output logic [15:0]            PC_VALUE,
	output logic                   PC_LOAD,
	output logic                   REG_INIT,
	output rsr_pkg::rsr_init_t     INIT_VALUES,
	output logic                   RAM_RETAIN,
	output logic                   INT_SERVICE,
	output logic                   RESUME_NEXT,
	output logic                   STOP_ACTIVE
);
	import rsr_pkg::*;

	localparam logic [RSR_CNT_W-1:0] STAB_LAST =
		RSR_CNT_W'(STAB_CYCLES - 1);

	// ************************************************************
	// reset release synchroniser
	// ************************************************************
	logic                 rst_meta_ff;
	logic                 rst_sync_ff;

	// two stage release of the asynchronous reset
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	wire                  rst_n = rst_sync_ff;

	// ************************************************************
	// state and storage
	// ************************************************************
	rsr_state_t           state_ff;
	rsr_state_t           nxt_state;
	logic [RSR_CNT_W-1:0] cnt_ff;
	logic [RSR_CNT_W-1:0] nxt_cnt;
	logic [7:0]           vec_lo_ff;
	logic [15:0]          pc_ff;
	logic                 pc_load_ff;
	logic                 init_ff;
	logic                 standby_ff;
	logic                 nxt_standby;
	logic [2:0]           cause_ff;
	logic                 stop_req_ff;
	logic                 svc_ff;
	logic                 next_ff;
	logic [7:0]           rdata_ff;
	rsr_irq_t             wake_ff;

	// ************************************************************
	// decode
	// ************************************************************
	function automatic logic is_state(input rsr_state_t s,
	                                  input rsr_state_t t);
		is_state = (s == t);
	endfunction

	// any of the three reset sources
	wire                  src_ext   = ~RESET_PIN_N;
	wire                  reset_req = src_ext | WDT_OVERRUN
	                                | MAIN_CLK_FAIL; // R1
	wire                  in_stop   = is_state(state_ff, RSR_ST_STOP)
	                                | is_state(state_ff, RSR_ST_SWAIT);
	wire                  cnt_done  = (cnt_ff == STAB_LAST); // R17
	// a masked request never wakes the device
	wire                  wake      = IRQ.req & ~IRQ.mask; // R9 R10
	// service decision from the flags latched at wake
	wire                  do_service = wake_ff.prio
	                                 ? (wake_ff.enable & wake_ff.in_service)
	                                 : wake_ff.enable; // R9
	wire                  wr_cause  = REG_WR & (REG_ADDR == RSR_REG_CAUSE);
	wire                  wr_ctrl   = REG_WR & (REG_ADDR == RSR_REG_CTRL);
	wire                  stop_go   = wr_ctrl & REG_WDATA[RSR_CTRL_STOP];
	wire [2:0]            cause_set = {MAIN_CLK_FAIL, WDT_OVERRUN, src_ext};

	// ************************************************************
	// sequencer next state
	// ************************************************************
	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_standby = standby_ff;
		if (reset_req) begin
			// any reset restarts the sequence, a reset taken from STOP also sets standby
			nxt_state = RSR_ST_RESET; // R2 R8
			nxt_cnt   = '0;
			if (in_stop)
				nxt_standby = 1'b1; // R7 R13
		end else begin
			case (state_ff)
			RSR_ST_RESET: begin
				// pin high or self releasing source gone
				nxt_state = RSR_ST_WAIT; // R4 R5
				nxt_cnt   = '0;
			end
			RSR_ST_WAIT: begin
				nxt_cnt = cnt_ff + 1'b1; // R17
				if (cnt_done)
					nxt_state = RSR_ST_VLO; // R4 R5
			end
			RSR_ST_VLO:
				nxt_state = RSR_ST_VHI;
			RSR_ST_VHI:
				nxt_state = RSR_ST_LOAD;
			RSR_ST_LOAD:
				nxt_state = RSR_ST_RUN;
			RSR_ST_RUN: begin
				if (stop_req_ff)
					nxt_state = RSR_ST_STOP;
			end
			RSR_ST_STOP: begin
				nxt_cnt = '0;
				if (wake)
					nxt_state = RSR_ST_SWAIT; // R9 R10
			end
			RSR_ST_SWAIT: begin
				nxt_cnt = cnt_ff + 1'b1; // R16 R17
				if (cnt_done)
					nxt_state = RSR_ST_RUN; // R16
			end
			default: begin
				nxt_state = RSR_ST_RESET;
				nxt_cnt   = '0;
			end
			endcase
		end
	end

	// state, counter and standby origin
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_ff   <= RSR_ST_RESET;
			cnt_ff     <= '0;
			standby_ff <= 1'b0; // R13
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			standby_ff <= nxt_standby;
		end
	end

	// ************************************************************
	// reset vector fetch and program counter load
	// ************************************************************
	// vector byte arrives the cycle after its read
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			vec_lo_ff  <= 8'h00;
			pc_ff      <= 16'h0000;
			pc_load_ff <= 1'b0;
			init_ff    <= 1'b0;
		end else begin
			pc_load_ff <= 1'b0;
			init_ff    <= 1'b0;
			if (is_state(state_ff, RSR_ST_VHI))
				vec_lo_ff <= VEC_DATA;
			if (is_state(state_ff, RSR_ST_LOAD) && !reset_req) begin
				pc_ff      <= {VEC_DATA, vec_lo_ff}; // R2 R11
				pc_load_ff <= 1'b1; // R11
				init_ff    <= 1'b1; // R12 R14 R15
			end
		end
	end

	// ************************************************************
	// stop request and wake handling
	// ************************************************************
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			stop_req_ff <= 1'b0;
			wake_ff     <= '0;
			svc_ff      <= 1'b0;
			next_ff     <= 1'b0;
		end else begin
			svc_ff  <= 1'b0;
			next_ff <= 1'b0;
			if (reset_req || is_state(state_ff, RSR_ST_RUN))
				stop_req_ff <= stop_go & ~reset_req;
			else if (stop_go)
				stop_req_ff <= 1'b1;
			if (is_state(state_ff, RSR_ST_STOP) && wake)
				wake_ff <= IRQ; // R9
			if (is_state(state_ff, RSR_ST_SWAIT) && cnt_done
			    && !reset_req) begin
				svc_ff  <= do_service; // R16
				next_ff <= ~do_service; // R16
			end
		end
	end

	// ************************************************************
	// reset cause flags, hardware set wins over clear
	// ************************************************************
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n)
			cause_ff <= 3'h0;
		else if (wr_cause)
			cause_ff <= (cause_ff & ~REG_WDATA[2:0]) | cause_set;
		else
			cause_ff <= cause_ff | cause_set; // R1
	end

	// ************************************************************
	// register read port
	// ************************************************************
	wire [7:0] status_word = {2'h0, standby_ff, stop_req_ff,
	                          cnt_done, state_ff};
	wire [7:0] rd_mux = (REG_ADDR == RSR_REG_STATUS) ? status_word
	                  : (REG_ADDR == RSR_REG_CAUSE)  ? {5'h00, cause_ff}
	                  : (REG_ADDR == RSR_REG_CTRL)   ? {7'h00, stop_req_ff}
	                  : 8'h00;

	// read data stands one cycle after the strobe
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n)
			rdata_ff <= 8'h00;
		else if (REG_RD)
			rdata_ff <= rd_mux;
		else
			rdata_ff <= 8'h00;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// core held in reset through the wait and vector fetch
	assign CORE_RESET  = is_state(state_ff, RSR_ST_RESET)
	                   | is_state(state_ff, RSR_ST_WAIT)
	                   | is_state(state_ff, RSR_ST_VLO)
	                   | is_state(state_ff, RSR_ST_VHI)
	                   | is_state(state_ff, RSR_ST_LOAD); // R17
	assign CPU_STALL   = in_stop; // R17
	// pins float during reset and the stabilization wait
	assign PORT_HIZ    = is_state(state_ff, RSR_ST_RESET)
	                   | is_state(state_ff, RSR_ST_WAIT); // R3 R7
	// main oscillator off in reset and in stop, sub always on
	assign MAIN_OSC_EN = ~is_state(state_ff, RSR_ST_RESET)
	                   & ~is_state(state_ff, RSR_ST_STOP); // R6
	assign SUB_OSC_EN  = 1'b1; // R6
	assign VEC_RD      = is_state(state_ff, RSR_ST_VLO)
	                   | is_state(state_ff, RSR_ST_VHI);
	assign VEC_ADDR    = is_state(state_ff, RSR_ST_VHI) ? RSR_VEC_ADDR_HI
	                   : RSR_VEC_ADDR_LO; // R2
	assign PC_VALUE    = pc_ff;
	assign PC_LOAD     = pc_load_ff;
	assign REG_INIT    = init_ff; // R12
	assign INIT_VALUES = RSR_INIT_VALUES; // R11 R14 R15
	assign RAM_RETAIN  = standby_ff; // R13
	assign INT_SERVICE = svc_ff;
	assign RESUME_NEXT = next_ff;
	assign STOP_ACTIVE = in_stop;
	assign REG_RDATA   = rdata_ff;

endmodule // rsr_reset_and_stop_release
`default_nettype wire

// File: rsr_vec_model.sv
`default_nettype none
module rsr_vec_model (
	input  wire logic        clk,
	input  wire logic        vec_rd,
	input  wire logic [15:0] vec_addr,
	input  wire logic [7:0]  vec_lo,
	input  wire logic [7:0]  vec_hi,
	output var logic [7:0]   vec_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// reset vector memory
	// ********
	initial vec_data = 8'h00;
	// byte answers one cycle after the read, junk that flips otherwise
	always @(posedge clk) begin
		if (vec_rd)
			vec_data <= vec_addr[0] ? vec_hi : vec_lo;
		else
			vec_data <= ~vec_data;
	end
endmodule // rsr_vec_model
`default_nettype wire

// File: rsr_reset_and_stop_release_chk.sv
`default_nettype none
module rsr_reset_and_stop_release_chk #(
	parameter int STAB_CYCLES = 8
) (
	input wire logic               CORE_CLK,
	input wire logic               RST_N,
	input wire logic               RESET_PIN_N,
	input wire logic               WDT_OVERRUN,
	input wire logic               MAIN_CLK_FAIL,
	input wire rsr_pkg::rsr_irq_t  IRQ,
	input wire logic [7:0]         VEC_DATA,
	input wire logic               CORE_RESET,
	input wire logic               CPU_STALL,
	input wire logic               RAM_RETAIN,
	input wire logic               PORT_HIZ,
	input wire logic               MAIN_OSC_EN,
	input wire logic               SUB_OSC_EN,
	input wire logic               VEC_RD,
	input wire logic [15:0]        VEC_ADDR,
	input wire logic [15:0]        PC_VALUE,
	input wire logic               PC_LOAD,
	input wire logic               REG_INIT,
	input wire rsr_pkg::rsr_init_t INIT_VALUES,
	input wire logic               INT_SERVICE,
	input wire logic               RESUME_NEXT,
	input wire logic               STOP_ACTIVE
);
	import rsr_pkg::*;
	// ********
	// helper logic: wait counters and latched wake decision
	// ********
	logic        req_any;
	logic        wake;
	logic [18:0] hiz_cnt_ff;
	logic [18:0] wait_cnt_ff;
	logic        woke_ff;
	logic        svc_ff;
	assign req_any = ~RESET_PIN_N | WDT_OVERRUN | MAIN_CLK_FAIL;
	assign wake = STOP_ACTIVE & IRQ.req & ~IRQ.mask;
	// count float cycles with no request, and cycles since wake
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			hiz_cnt_ff <= '0;
			wait_cnt_ff <= '0;
			woke_ff <= 1'b0;
			svc_ff <= 1'b0;
		end else begin
			hiz_cnt_ff <= (PORT_HIZ && !req_any) ? hiz_cnt_ff + 19'h1 : '0;
			wait_cnt_ff <= woke_ff ? wait_cnt_ff + 19'h1 : '0;
			woke_ff <= STOP_ACTIVE & ~req_any & (woke_ff | wake);
			if (wake && !woke_ff)
				svc_ff <= IRQ.prio ? IRQ.enable & IRQ.in_service : IRQ.enable;
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	a_reset_entry: assert property (req_any |=>
		CORE_RESET && PORT_HIZ && !MAIN_OSC_EN) else $error("reset entry");
	a_sub_osc_run: assert property (SUB_OSC_EN)
		else $error("subsystem osc stopped");
	a_hiz_in_reset: assert property (PORT_HIZ |-> CORE_RESET)
		else $error("pins float outside reset");
	a_stab_length: assert property ($fell(PORT_HIZ) |->
		hiz_cnt_ff == STAB_CYCLES + 1 && VEC_RD && VEC_ADDR == 16'h0000)
		else $error("stabilization wait length");
	a_vec_order: assert property (VEC_RD && VEC_ADDR == 16'h0000 |=>
		VEC_RD && VEC_ADDR == 16'h0001) else $error("vector read order");
	a_pc_from_vec: assert property (VEC_RD && VEC_ADDR == 16'h0001 |->
		##2 PC_LOAD && !CORE_RESET &&
		PC_VALUE == {$past(VEC_DATA), $past(VEC_DATA, 2)})
		else $error("program counter not from vector");
	a_init_values: assert property (REG_INIT |->
		PC_LOAD && INIT_VALUES == RSR_INIT_VALUES) else $error("init values");
	a_mask_hold: assert property (
		STOP_ACTIVE && !woke_ff && !wake && !req_any |=> STOP_ACTIVE)
		else $error("left stop without unmasked request");
	a_wake_time: assert property (INT_SERVICE || RESUME_NEXT |->
		woke_ff && wait_cnt_ff == STAB_CYCLES && !STOP_ACTIVE)
		else $error("wake wait length");
	a_svc_choice: assert property (INT_SERVICE || RESUME_NEXT |->
		INT_SERVICE == svc_ff && !(INT_SERVICE && RESUME_NEXT))
		else $error("service choice");
	a_stall_stop: assert property (CPU_STALL == STOP_ACTIVE)
		else $error("stall differs from stop");
	a_retain_stop: assert property (STOP_ACTIVE && req_any |=>
		RAM_RETAIN) else $error("retain not set on reset from stop");
	c_service: cover property (INT_SERVICE);
	c_resume: cover property (RESUME_NEXT);
	c_masked: cover property (STOP_ACTIVE && IRQ.req && IRQ.mask);
	c_load: cover property (PC_LOAD);
endmodule // rsr_reset_and_stop_release_chk
bind rsr_reset_and_stop_release rsr_reset_and_stop_release_chk #(
	.STAB_CYCLES(STAB_CYCLES)) u_chk (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N), .RESET_PIN_N(RESET_PIN_N),
	.WDT_OVERRUN(WDT_OVERRUN), .MAIN_CLK_FAIL(MAIN_CLK_FAIL), .IRQ(IRQ),
	.VEC_DATA(VEC_DATA), .CORE_RESET(CORE_RESET), .PORT_HIZ(PORT_HIZ),
	.CPU_STALL(CPU_STALL), .RAM_RETAIN(RAM_RETAIN),
	.MAIN_OSC_EN(MAIN_OSC_EN), .SUB_OSC_EN(SUB_OSC_EN), .VEC_RD(VEC_RD),
	.VEC_ADDR(VEC_ADDR), .PC_VALUE(PC_VALUE), .PC_LOAD(PC_LOAD),
	.REG_INIT(REG_INIT), .INIT_VALUES(INIT_VALUES),
	.INT_SERVICE(INT_SERVICE), .RESUME_NEXT(RESUME_NEXT),
	.STOP_ACTIVE(STOP_ACTIVE));
`default_nettype wire

// File: tb_reset_and_stop_release.sv
`default_nettype none
module tb_reset_and_stop_release;
	timeunit 1ns;
	timeprecision 1ps;
	import rsr_pkg::*;
	// ********
	// stimulus, reference model and checks
	// ********
	localparam int STAB = 8;
	logic        clk = 1'b0, rst_n = 1'b0, pin_n = 1'b0;
	logic        wdt = 1'b0, cfail = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [1:0]  reg_addr = 2'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, vec_data, vlo, vhi;
	logic [7:0]  seed = 8'h12;
	logic [15:0] vec_addr, pc_value;
	logic        vec_rd, pc_load, stop_active, int_service, resume_next;
	rsr_irq_t    irq = '0;
	int          exp_pc[$];
	int          err_total = 0;
	int          checks_done = 0;
	always #5 clk = ~clk;
	rsr_reset_and_stop_release #(.STAB_CYCLES(STAB)) dut (
		.CORE_CLK(clk), .RST_N(rst_n), .RESET_PIN_N(pin_n),
		.WDT_OVERRUN(wdt), .MAIN_CLK_FAIL(cfail), .IRQ(irq),
		.VEC_DATA(vec_data), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.CORE_RESET(), .CPU_STALL(), .PORT_HIZ(), .MAIN_OSC_EN(),
		.SUB_OSC_EN(), .VEC_RD(vec_rd), .VEC_ADDR(vec_addr),
		.PC_VALUE(pc_value), .PC_LOAD(pc_load), .REG_INIT(),
		.INIT_VALUES(), .RAM_RETAIN(), .INT_SERVICE(int_service),
		.RESUME_NEXT(resume_next), .STOP_ACTIVE(stop_active));
	rsr_vec_model u_vec (.clk(clk), .vec_rd(vec_rd), .vec_addr(vec_addr),
		.vec_lo(vlo), .vec_hi(vhi), .vec_data(vec_data));
	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic final_report();
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// random vector bytes, expected program counter queued
	task automatic pick_vec();
		logic [7:0] lo;
		lo = lfsr_next(seed);
		seed = lfsr_next(lo);
		vlo <= lo;
		vhi <= seed;
		exp_pc.push_back(int'({seed, lo}));
	endtask
	task automatic wait_pc();
		for (int i = 0; i < 300 && pc_load !== 1'b1; i++)
			@(negedge clk);
		chk("pc_load", 16'h1, {15'h0, pc_load});
		chk("pc_value", 16'(exp_pc.pop_front()), pc_value);
	endtask
	task automatic do_reset(input int src);
		logic [7:0] d;
		pick_vec();
		@(posedge clk);
		pin_n <= (src != 0);
		wdt <= (src == 1);
		cfail <= (src == 2);
		repeat (3) @(posedge clk);
		pin_n <= 1'b1;
		wdt <= 1'b0;
		cfail <= 1'b0;
		wait_pc();
		rd(RSR_REG_CAUSE, d);
		chk("cause", 16'(1 << src), {8'h0, d});
		wr(RSR_REG_CAUSE, 8'h07);
		rd(RSR_REG_CAUSE, d);
		chk("cause_clr", 16'h0, {8'h0, d});
	endtask
	task automatic enter_stop();
		wr(RSR_REG_CTRL, 8'h01);
		for (int i = 0; i < 20 && stop_active !== 1'b1; i++)
			@(negedge clk);
		chk("stop", 16'h1, {15'h0, stop_active});
	endtask
	// watchdog against a hang
	initial begin
		#200000;
		err_total++;
		final_report();
	end
	initial begin
		logic [7:0] d;
		int c;
		int svc;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		pick_vec();
		pin_n <= 1'b1;
		wait_pc();
		rd(RSR_REG_STATUS, d);
		chk("status", 16'h0007, {10'h0, d[5], 2'h0, d[2:0]});
		for (c = 0; c < 3; c++)
			do_reset(c);
		wr(2'h3, 8'hff);
		rd(2'h3, d);
		chk("unmapped", 16'h0, {8'h0, d});
		// every flag combination, masked ones held then unmasked
		for (c = 0; c < 16; c++) begin
			enter_stop();
			irq <= '{req: 1'b1, mask: c[3], prio: c[2], enable: c[1],
				in_service: c[0]};
			if (c[3]) begin
				repeat (3 * STAB) @(posedge clk);
				#1 chk("stop_hold", 16'h1, {15'h0, stop_active});
				irq.mask <= 1'b0;
			end
			svc = c[2] ? (c[1] & c[0]) : c[1];
			for (int i = 0; i < 60 && (int_service | resume_next) !== 1'b1; i++)
				@(negedge clk);
			chk("service", 16'(svc), {15'h0, int_service});
			chk("resume", 16'(1 - svc), {15'h0, resume_next});
			@(posedge clk);
			irq <= '0;
		end
		enter_stop();
		do_reset(0);
		rd(RSR_REG_STATUS, d);
		chk("retain", 16'h0027, {10'h0, d[5], 2'h0, d[2:0]});
		final_report();
	end
endmodule // tb_reset_and_stop_release
`default_nettype wire
